// [verilog/dma_pkg.sv]
// Shared constants and types for the descriptor-driven DMA engine
package dma_pkg;
  // Channel and level counts
  localparam int NUM_CH          = 4;
  localparam int CH_W            = 2;
  localparam int NUM_LVL         = 4;
  localparam int BEATS_PER_BURST = 1;
  // Stride of one descriptor entry, as a shift: sixteen bytes
  localparam int ENTRY_SHIFT     = 4;

  // Register offsets on the plain register port (byte addresses)
  localparam logic [7:0] OFS_CONTROL       = 8'h00;
  localparam logic [7:0] OFS_PRIORITY_CTRL = 8'h04;
  localparam logic [7:0] OFS_DESC_BASE     = 8'h08;
  localparam logic [7:0] OFS_WB_BASE       = 8'h0c;
  localparam logic [7:0] OFS_CH_SELECT     = 8'h10;
  localparam logic [7:0] OFS_CH_CTRL_A     = 8'h14;
  localparam logic [7:0] OFS_CH_CONFIG     = 8'h18;
  localparam logic [7:0] OFS_CH_STATUS     = 8'h1c;
  localparam logic [7:0] OFS_CH_INT_FLAGS  = 8'h20;
  localparam logic [7:0] OFS_PENDING       = 8'h24;
  localparam logic [7:0] OFS_BUSY          = 8'h28;
  localparam logic [7:0] OFS_LEVEL_EXEC    = 8'h2c;
  localparam logic [7:0] OFS_SW_TRIGGER    = 8'h30;

  // Register field positions
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_LVL_EN_LSB  = 8;
  localparam int PRI_RR_EN_LSB    = 0;
  localparam int PRI_LAST_LSB     = 8;
  localparam int CHA_ENABLE_BIT   = 0;
  localparam int CHA_SUSPEND_BIT  = 1;
  localparam int CHA_RESUME_BIT   = 2;
  localparam int CFG_LVL_LSB      = 0;
  localparam int CFG_IE_TC_BIT    = 4;
  localparam int CFG_IE_SUSP_BIT  = 5;
  localparam int STAT_PEND_BIT    = 0;
  localparam int STAT_BUSY_BIT    = 1;
  localparam int STAT_FETCH_ERROR_STATUS_BIT    = 2;
  localparam int FLAG_TC_BIT      = 0;
  localparam int FLAG_SUSP_BIT    = 1;

  // Descriptor layout, 128 bits per entry
  localparam int DESC_VALID_BIT   = 0;
  localparam int DESC_BEAT_EV_BIT = 1;
  localparam int DESC_BLK_EV_BIT  = 2;
  localparam int DESC_ACTION_BIT  = 3;
  localparam int DESC_CNT_LSB     = 16;
  localparam int DESC_SRC_LSB     = 32;
  localparam int DESC_DST_LSB     = 64;
  localparam int DESC_NEXT_LSB    = 96;
  localparam logic [31:0] NULL_DESC_ADDR = 32'h0000_0000;

  // Block-end action encoding
  localparam logic ACTION_DISABLE = 1'b0;
  localparam logic ACTION_SUSPEND = 1'b1;

  // Engine sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE       = 8'h01,
    ST_FETCH      = 8'h02,
    ST_READ       = 8'h04,
    ST_WRITE      = 8'h08,
    ST_WB_CNT     = 8'h10,
    ST_WB_FULL    = 8'h20,
    ST_FETCH_NEXT = 8'h40,
    ST_WB_NEXT    = 8'h80
  } engine_state_t;
endpackage

// [verilog/dma_descriptor_arbiter.sv]
// Descriptor-driven DMA engine with priority and round-robin channel arbiter
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps

module dma_descriptor_arbiter (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_in,
  input  wire logic [7:0]                 reg_addr_in,
  input  wire logic [31:0]                reg_wdata_in,
  input  wire logic                       reg_write_in,
  input  wire logic                       reg_read_in,
  output logic      [31:0]                reg_rdata_out,
  input  wire logic [dma_pkg::NUM_CH-1:0] trigger_in,
  output logic                            fetch_req_out,
  output logic                            fetch_write_out,
  output logic      [31:0]                fetch_addr_out,
  output logic      [127:0]               fetch_wdata_out,
  input  wire logic                       fetch_ack_in,
  input  wire logic [127:0]               fetch_rdata_in,
  output logic                            data_req_out,
  output logic                            data_write_out,
  output logic      [31:0]                data_addr_out,
  output logic      [31:0]                data_wdata_out,
  input  wire logic                       data_ack_in,
  input  wire logic [31:0]                data_rdata_in,
  output logic                            beat_event_out,
  output logic                            block_event_out,
  output logic      [dma_pkg::CH_W-1:0]   event_channel_out
);
  localparam int N = dma_pkg::NUM_CH;
  localparam int W = dma_pkg::CH_W;
  localparam int L = dma_pkg::NUM_LVL;
  typedef struct packed {
    dma_pkg::engine_state_t st;
    logic                   eng_en;
    logic [L-1:0]           lvl_en;
    logic [L-1:0]           rr_en;
    logic [L-1:0][W-1:0]    last;
    logic [31:0]            base;
    logic [31:0]            wb;
    logic [W-1:0]           sel;
    logic [N-1:0]           en, susp, pend, busy;
    logic [N-1:0]           ongoing, ended, fetch_error_status;
    logic [N-1:0]           flag_tc, flag_susp, ie_tc, ie_susp;
    logic [N-1:0][1:0]      lvl;
    logic [W-1:0]           act_ch;
    logic                   act_valid;
    logic [127:0]           desc;
    logic [31:0]            f_addr;
    logic [127:0]           f_wdata;
    logic                   f_we;
    logic [31:0]            d_addr;
    logic [31:0]            d_wdata;
    logic                   d_we;
    logic [31:0]            rdata;
    logic                   beat_ev;
    logic                   block_ev;
    logic [W-1:0]           ev_ch;
  } engine_t;
  engine_t        s;
  engine_t        next_s;
  logic [N-1:0]   queue;
  logic [L-1:0]   lvl_exec;
  logic           win_found;
  logic [W-1:0]   win;
  logic [W-1:0]   arb_idx;
  logic [31:0]    act_desc_addr, act_wb_addr, win_desc_addr, win_wb_addr;
  logic [15:0]    cnt_dec;
  logic [127:0]   desc_done;
  // Queue excludes suspended and disabled channels; a suspended channel keeps its pend bit, disabling clears it
  assign queue = s.pend & s.en & ~s.susp;
  // Level executing bits, one per priority level
  for (genvar gl = 0; gl < L; gl++)
  begin : g_lvl
    logic [N-1:0] hit;
    for (genvar gc = 0; gc < N; gc++)
    begin : g_ch
      assign hit[gc] = (s.pend[gc] | s.busy[gc]) && (s.lvl[gc] == 2'(gl));
    end
    assign lvl_exec[gl] = |hit;
  end
  // Entry addresses; sharing one region works since both use the same stride
  assign act_desc_addr = s.base + (32'(s.act_ch) << dma_pkg::ENTRY_SHIFT);
  assign act_wb_addr   = s.wb + (32'(s.act_ch) << dma_pkg::ENTRY_SHIFT);
  assign win_desc_addr = s.base + (32'(win) << dma_pkg::ENTRY_SHIFT);
  assign win_wb_addr   = s.wb + (32'(win) << dma_pkg::ENTRY_SHIFT);

  // Count after one burst, and the finished descriptor with valid cleared
  assign cnt_dec = s.desc[dma_pkg::DESC_CNT_LSB +: 16] - 16'(dma_pkg::BEATS_PER_BURST);
  always_comb
  begin
    desc_done = s.desc;
    desc_done[dma_pkg::DESC_CNT_LSB +: 16] = cnt_dec;
    desc_done[dma_pkg::DESC_VALID_BIT] = 1'b0;
  end
  // Arbiter: highest enabled level first, then static or rotating order
  always_comb
  begin
    win_found = 1'b0;
    win       = '0;
    arb_idx   = '0;
    for (int l = L - 1; l >= 0; l--)
    begin
      for (int k = 0; k < N; k++)
      begin
        arb_idx = s.rr_en[l] ? s.last[l] + W'(1) + W'(k) : W'(k);
        if (!win_found && s.eng_en && s.lvl_en[l] && queue[arb_idx] &&
            s.lvl[arb_idx] == 2'(l))
        begin
          win_found = 1'b1;
          win       = arb_idx;
        end
      end
    end
  end

  // Next-state logic: register port, sequencer, then triggers so sets win
  always_comb
  begin
    next_s          = s;
    next_s.beat_ev  = 1'b0;
    next_s.block_ev = 1'b0;
    // Register reads answer one cycle later; unmapped reads return zero
    if (reg_read_in)
    begin
      case (reg_addr_in)
        dma_pkg::OFS_CONTROL:       next_s.rdata = {20'h0, s.lvl_en, 7'h0, s.eng_en};
        dma_pkg::OFS_PRIORITY_CTRL: next_s.rdata = {16'h0, s.last, 4'h0, s.rr_en};
        dma_pkg::OFS_DESC_BASE:    next_s.rdata = s.base;
        dma_pkg::OFS_WB_BASE:      next_s.rdata = s.wb;
        dma_pkg::OFS_CH_SELECT:    next_s.rdata = {30'h0, s.sel};
        dma_pkg::OFS_CH_CTRL_A:    next_s.rdata = {31'h0, s.en[s.sel]};
        dma_pkg::OFS_CH_CONFIG:
          next_s.rdata = {26'h0, s.ie_susp[s.sel], s.ie_tc[s.sel], 2'h0, s.lvl[s.sel]};
        dma_pkg::OFS_CH_STATUS:
          next_s.rdata = {29'h0, s.fetch_error_status[s.sel], s.busy[s.sel], s.pend[s.sel]};
        dma_pkg::OFS_CH_INT_FLAGS: next_s.rdata = {30'h0, s.flag_susp[s.sel], s.flag_tc[s.sel]};
        dma_pkg::OFS_PENDING:      next_s.rdata = {28'h0, s.pend};
        dma_pkg::OFS_BUSY:         next_s.rdata = {28'h0, s.busy};
        dma_pkg::OFS_LEVEL_EXEC:   next_s.rdata = {28'h0, lvl_exec};
        default:                   next_s.rdata = 32'h0;
      endcase
    end

    // Register writes; channel commands act on the selected channel
    if (reg_write_in)
    begin
      case (reg_addr_in)
        dma_pkg::OFS_CONTROL:
        begin
          next_s.eng_en = reg_wdata_in[dma_pkg::CTRL_ENABLE_BIT];
          next_s.lvl_en = reg_wdata_in[dma_pkg::CTRL_LVL_EN_LSB +: L];
        end
        dma_pkg::OFS_PRIORITY_CTRL: next_s.rr_en = reg_wdata_in[dma_pkg::PRI_RR_EN_LSB +: L];
        // Base addresses only move while the engine is off
        dma_pkg::OFS_DESC_BASE:     if (!s.eng_en) next_s.base = reg_wdata_in;
        dma_pkg::OFS_WB_BASE:       if (!s.eng_en) next_s.wb = reg_wdata_in;
        dma_pkg::OFS_CH_SELECT:     next_s.sel = reg_wdata_in[W-1:0];
        dma_pkg::OFS_CH_CTRL_A:
        begin
          next_s.en[s.sel] = reg_wdata_in[dma_pkg::CHA_ENABLE_BIT];
          if (!reg_wdata_in[dma_pkg::CHA_ENABLE_BIT])
          begin
            next_s.pend[s.sel]  = 1'b0;
            next_s.busy[s.sel]  = 1'b0;
            next_s.susp[s.sel]  = 1'b0;
            next_s.ended[s.sel] = 1'b0;
          end
          else if (reg_wdata_in[dma_pkg::CHA_SUSPEND_BIT])
          begin
            next_s.susp[s.sel] = 1'b1;
            next_s.busy[s.sel] = 1'b0;
          end
          else if (reg_wdata_in[dma_pkg::CHA_RESUME_BIT] && s.susp[s.sel])
          begin
            // Resuming past the last block has nowhere to go
            if (s.ended[s.sel])
            begin
              next_s.fetch_error_status[s.sel]      = 1'b1;
              next_s.flag_susp[s.sel] = 1'b1;
            end
            else
              next_s.susp[s.sel] = 1'b0;
          end
        end
        dma_pkg::OFS_CH_CONFIG:
        begin
          next_s.lvl[s.sel]     = reg_wdata_in[dma_pkg::CFG_LVL_LSB +: 2];
          next_s.ie_tc[s.sel]   = reg_wdata_in[dma_pkg::CFG_IE_TC_BIT];
          next_s.ie_susp[s.sel] = reg_wdata_in[dma_pkg::CFG_IE_SUSP_BIT];
        end
        // Write one to clear; a set later in this cycle still wins
        dma_pkg::OFS_CH_INT_FLAGS:
        begin
          if (reg_wdata_in[dma_pkg::FLAG_TC_BIT])   next_s.flag_tc[s.sel] = 1'b0;
          if (reg_wdata_in[dma_pkg::FLAG_SUSP_BIT]) next_s.flag_susp[s.sel] = 1'b0;
        end
        default: ;
      endcase
    end

    // Sequencer
    case (s.st)
      dma_pkg::ST_IDLE:
      begin
        if (s.act_valid && (!win_found || win != s.act_ch))
        begin
          // Park the outgoing channel's progress before anyone else loads
          next_s.f_addr  = act_wb_addr;
          next_s.f_wdata = s.desc;
          next_s.f_we    = 1'b1;
          next_s.st      = dma_pkg::ST_WB_CNT;
        end
        else if (win_found)
        begin
          next_s.pend[win]        = 1'b0;
          next_s.busy[win]        = 1'b1;
          next_s.last[s.lvl[win]] = win;
          next_s.act_ch           = win;
          if (s.act_valid)
          begin
            next_s.d_addr = s.desc[dma_pkg::DESC_SRC_LSB +: 32];
            next_s.d_we   = 1'b0;
            next_s.st     = dma_pkg::ST_READ;
          end
          else
          begin
            next_s.f_addr = s.ongoing[win] ? win_wb_addr : win_desc_addr;
            next_s.f_we   = 1'b0;
            next_s.st     = dma_pkg::ST_FETCH;
          end
        end
      end
      dma_pkg::ST_FETCH:
        if (fetch_ack_in)
        begin
          next_s.desc = fetch_rdata_in;
          if (!fetch_rdata_in[dma_pkg::DESC_VALID_BIT])
          begin
            next_s.susp[s.act_ch]      = 1'b1;
            next_s.fetch_error_status[s.act_ch]      = 1'b1;
            next_s.flag_susp[s.act_ch] = 1'b1;
            next_s.busy[s.act_ch]      = 1'b0;
            next_s.st                  = dma_pkg::ST_IDLE;
          end
          else
          begin
            next_s.act_valid        = 1'b1;
            next_s.ongoing[s.act_ch] = 1'b1;
            next_s.d_addr = fetch_rdata_in[dma_pkg::DESC_SRC_LSB +: 32];
            next_s.d_we   = 1'b0;
            next_s.st     = dma_pkg::ST_READ;
          end
        end
      dma_pkg::ST_READ:
        if (data_ack_in)
        begin
          next_s.d_wdata = data_rdata_in;
          next_s.d_addr  = s.desc[dma_pkg::DESC_DST_LSB +: 32];
          next_s.d_we    = 1'b1;
          next_s.st      = dma_pkg::ST_WRITE;
        end
      dma_pkg::ST_WRITE:
        if (data_ack_in)
        begin
          next_s.desc[dma_pkg::DESC_CNT_LSB +: 16] = cnt_dec;
          next_s.beat_ev = s.desc[dma_pkg::DESC_BEAT_EV_BIT];
          next_s.ev_ch   = s.act_ch;
          if (cnt_dec == 16'h0)
          begin
            next_s.desc    = desc_done;
            next_s.f_wdata = desc_done;
            next_s.f_addr  = act_wb_addr;
            next_s.f_we    = 1'b1;
            next_s.st      = dma_pkg::ST_WB_FULL;
          end
          else
          begin
            // Channel re-enters the queue and keeps its busy flag
            next_s.pend[s.act_ch] = next_s.en[s.act_ch];
            next_s.st             = dma_pkg::ST_IDLE;
          end
        end
      dma_pkg::ST_WB_FULL:
        if (fetch_ack_in)
        begin
          if (s.ie_tc[s.act_ch]) next_s.flag_tc[s.act_ch] = 1'b1;
          next_s.block_ev = s.desc[dma_pkg::DESC_BLK_EV_BIT];
          next_s.ev_ch    = s.act_ch;
          next_s.busy[s.act_ch] = 1'b0;
          next_s.act_valid      = 1'b0;
          if (s.desc[dma_pkg::DESC_NEXT_LSB +: 32] == dma_pkg::NULL_DESC_ADDR)
          begin
            next_s.ongoing[s.act_ch] = 1'b0;
            if (s.desc[dma_pkg::DESC_ACTION_BIT] == dma_pkg::ACTION_SUSPEND)
            begin
              next_s.susp[s.act_ch]  = 1'b1;
              next_s.ended[s.act_ch] = 1'b1;
              if (s.ie_susp[s.act_ch]) next_s.flag_susp[s.act_ch] = 1'b1;
            end
            else
            begin
              next_s.en[s.act_ch]   = 1'b0;
              next_s.pend[s.act_ch] = 1'b0;
            end
            next_s.st = dma_pkg::ST_IDLE;
          end
          else
          begin
            next_s.f_addr = s.desc[dma_pkg::DESC_NEXT_LSB +: 32];
            next_s.f_we   = 1'b0;
            next_s.st     = dma_pkg::ST_FETCH_NEXT;
          end
        end
      dma_pkg::ST_FETCH_NEXT:
        if (fetch_ack_in)
        begin
          next_s.f_wdata = fetch_rdata_in;
          next_s.f_addr  = act_wb_addr;
          next_s.f_we    = 1'b1;
          next_s.st      = dma_pkg::ST_WB_NEXT;
        end
      dma_pkg::ST_WB_NEXT:
        // Arbitration only resumes once the copy has landed
        if (fetch_ack_in)
          next_s.st = dma_pkg::ST_IDLE;
      dma_pkg::ST_WB_CNT:
        if (fetch_ack_in)
        begin
          next_s.act_valid = 1'b0;
          next_s.st        = dma_pkg::ST_IDLE;
        end
      default:
        next_s.st = dma_pkg::ST_IDLE;
    endcase
    // Triggers last, so a software trigger beats a grant clear in the same cycle; a hardware trigger is ignored while pend is set
    for (int i = 0; i < N; i++)
    begin
      if (trigger_in[i] && s.en[i] && !s.susp[i] && !s.pend[i])
        next_s.pend[i] = 1'b1;
      if (reg_write_in && reg_addr_in == dma_pkg::OFS_SW_TRIGGER && reg_wdata_in[i] &&
          s.en[i] && !s.susp[i])
        next_s.pend[i] = 1'b1;
    end
  end
  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      s    <= '0;
      s.st <= dma_pkg::ST_IDLE;
    end
    else
      s <= next_s;
  end
  // Bus requests follow the state; addresses and data come from flops
  assign fetch_req_out     = s.st inside {dma_pkg::ST_FETCH, dma_pkg::ST_WB_CNT,
                             dma_pkg::ST_WB_FULL, dma_pkg::ST_FETCH_NEXT,
                             dma_pkg::ST_WB_NEXT};
  assign fetch_write_out   = s.f_we;
  assign fetch_addr_out    = s.f_addr;
  assign fetch_wdata_out   = s.f_wdata;
  assign data_req_out      = s.st inside {dma_pkg::ST_READ, dma_pkg::ST_WRITE};
  assign data_write_out    = s.d_we;
  assign data_addr_out     = s.d_addr;
  assign data_wdata_out    = s.d_wdata;
  assign reg_rdata_out     = s.rdata;
  assign beat_event_out    = s.beat_ev;
  assign block_event_out   = s.block_ev;
  assign event_channel_out = s.ev_ch;
endmodule

// [sim/dma_arbiter_checker_asserts.sv]
// Port assertions for the descriptor DMA engine
`timescale 1ns/100ps
module dma_arbiter_checker (
  input wire logic         sys_clk_in,
  input wire logic         rst_in,
  input wire logic         fetch_req_out,
  input wire logic         fetch_write_out,
  input wire logic [31:0]  fetch_addr_out,
  input wire logic [127:0] fetch_wdata_out,
  input wire logic         fetch_ack_in,
  input wire logic         data_req_out,
  input wire logic         data_write_out,
  input wire logic [31:0]  data_wdata_out,
  input wire logic         data_ack_in,
  input wire logic [31:0]  data_rdata_in,
  input wire logic         beat_event_out,
  input wire logic         block_event_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // Bus requests hold until answered
  property p_fh;
    fetch_req_out && !fetch_ack_in |=> fetch_req_out && $stable(fetch_addr_out);
  endproperty
  property p_dh;
    data_req_out && !data_ack_in |=> data_req_out && $stable(data_write_out);
  endproperty
  property p_al;
    fetch_req_out |-> fetch_addr_out[3:0] == 4'h0;
  endproperty
  property p_one;
    !(fetch_req_out && data_req_out);
  endproperty
  // Beat read is written straight on to the destination
  property p_wd;
    data_req_out && data_ack_in && !data_write_out |=>
      data_req_out && data_write_out && data_wdata_out == $past(data_rdata_in);
  endproperty
  property p_bt;
    beat_event_out |-> $past(data_req_out && data_ack_in && data_write_out);
  endproperty
  property p_bk;
    block_event_out |-> $past(fetch_req_out && fetch_ack_in && fetch_write_out);
  endproperty
  property p_vz;
    fetch_req_out && fetch_write_out && fetch_wdata_out[31:16] == 16'h0 |->
      !fetch_wdata_out[0];
  endproperty
  a_fh: assert property (p_fh) else $error("fetch request moved early");
  a_dh: assert property (p_dh) else $error("data request moved early");
  a_al: assert property (p_al) else $error("entry address off stride");
  a_one: assert property (p_one) else $error("both buses requested");
  a_wd: assert property (p_wd) else $error("beat data not forwarded");
  a_bt: assert property (p_bt) else $error("beat event without beat");
  a_bk: assert property (p_bk) else $error("block event without write-back");
  a_vz: assert property (p_vz) else $error("finished entry still valid");
  c_blk: cover property (block_event_out);
  c_beat: cover property (beat_event_out);
  c_wb: cover property (fetch_req_out && fetch_write_out && fetch_ack_in);
endmodule

bind dma_descriptor_arbiter dma_arbiter_checker chk (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .fetch_req_out(fetch_req_out),
  .fetch_write_out(fetch_write_out), .fetch_addr_out(fetch_addr_out),
  .fetch_wdata_out(fetch_wdata_out), .fetch_ack_in(fetch_ack_in),
  .data_req_out(data_req_out), .data_write_out(data_write_out),
  .data_wdata_out(data_wdata_out), .data_ack_in(data_ack_in),
  .data_rdata_in(data_rdata_in), .beat_event_out(beat_event_out),
  .block_event_out(block_event_out)
);

// [sim/dma_mem_model.sv]
// Memory-side partner: descriptor space and data space with set latency
`timescale 1ns/100ps
module dma_mem_model (
  input  wire logic         sys_clk_in,
  input  wire logic [3:0]   delay_in,
  input  wire logic         fetch_req_in,
  input  wire logic         fetch_write_in,
  input  wire logic [31:0]  fetch_addr_in,
  input  wire logic [127:0] fetch_wdata_in,
  output logic              fetch_ack_out,
  output logic      [127:0] fetch_rdata_out,
  input  wire logic         data_req_in,
  input  wire logic         data_write_in,
  input  wire logic [31:0]  data_addr_in,
  input  wire logic [31:0]  data_wdata_in,
  output logic              data_ack_out,
  output logic      [31:0]  data_rdata_out
);
  logic [127:0] desc [logic [31:0]];
  logic [31:0]  dmem [logic [31:0]];
  logic [31:0]  rd_log [$];
  logic [3:0]   fwait = 4'h0;
  logic [3:0]   dwait = 4'h0;
  initial
  begin
    fetch_ack_out = 1'b0;
    data_ack_out = 1'b0;
    fetch_rdata_out = '0;
    data_rdata_out = '0;
  end
  // Idle read lines flip each cycle so stale data never looks valid
  always @(posedge sys_clk_in)
  begin
    fetch_ack_out <= 1'b0;
    data_ack_out <= 1'b0;
    fetch_rdata_out <= ~fetch_rdata_out;
    data_rdata_out <= ~data_rdata_out;
    fwait <= (fetch_req_in && !fetch_ack_out) ? fwait + 4'h1 : 4'h0;
    dwait <= (data_req_in && !data_ack_out) ? dwait + 4'h1 : 4'h0;
    if (fetch_req_in && !fetch_ack_out && fwait >= delay_in)
    begin
      fetch_ack_out <= 1'b1;
      if (fetch_write_in)
        desc[fetch_addr_in] = fetch_wdata_in;
      else
      begin
        fetch_rdata_out <= desc[fetch_addr_in];
        rd_log.push_back(fetch_addr_in);
      end
    end
    if (data_req_in && !data_ack_out && dwait >= delay_in)
    begin
      data_ack_out <= 1'b1;
      if (data_write_in)
        dmem[data_addr_in] = data_wdata_in;
      else
        data_rdata_out <= dmem[data_addr_in];
    end
  end
endmodule

// [sim/testbench.sv]
// Register-level tests of the DMA engine against the memory model
`timescale 1ns/100ps
module testbench;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   addr = 8'h00;
  logic [31:0]  wdata = 32'h0;
  logic         wr_s = 1'b0;
  logic         rd_s = 1'b0;
  logic [31:0]  rdata;
  logic [3:0]   trig = 4'h0;
  logic [3:0]   dly = 4'h0;
  logic         f_req, f_we, f_ack, d_req, d_we, d_ack;
  logic [31:0]  f_addr, d_addr, d_wd, d_rd;
  logic [127:0] f_wd, f_rd;
  int           err_total = 0;
  int           total_checks = 0;
  int           c;
  int           nbeat = 0;
  int           nblk = 0;
  logic         bev, kev;
  logic [1:0]   evc;
  logic [1:0]   kch = 2'h0;

  dma_descriptor_arbiter uut (
    .sys_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_rdata_out(rdata), .trigger_in(trig),
    .fetch_req_out(f_req), .fetch_write_out(f_we), .fetch_addr_out(f_addr),
    .fetch_wdata_out(f_wd), .fetch_ack_in(f_ack), .fetch_rdata_in(f_rd),
    .data_req_out(d_req), .data_write_out(d_we), .data_addr_out(d_addr),
    .data_wdata_out(d_wd), .data_ack_in(d_ack), .data_rdata_in(d_rd),
    .beat_event_out(bev), .block_event_out(kev), .event_channel_out(evc)
  );
  dma_mem_model m (
    .sys_clk_in(clk), .delay_in(dly), .fetch_req_in(f_req), .fetch_write_in(f_we),
    .fetch_addr_in(f_addr), .fetch_wdata_in(f_wd), .fetch_ack_out(f_ack),
    .fetch_rdata_out(f_rd), .data_req_in(d_req), .data_write_in(d_we),
    .data_addr_in(d_addr), .data_wdata_in(d_wd), .data_ack_out(d_ack),
    .data_rdata_out(d_rd)
  );

  always #50 clk = ~clk;

  // Event pulses last one cycle, so count them at every edge
  always @(posedge clk)
  begin
    if (bev) nbeat <= nbeat + 1;
    if (kev) nblk <= nblk + 1;
    if (kev) kch <= evc;
  end

  function automatic logic [127:0] mk(input logic [15:0] n, input logic [3:0] f);
    return {32'h0, 32'h800, 32'h400, n, 12'h0, f};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(nm, v, e);
  endtask
  // Bounded waits: engine idle, or n descriptor reads seen
  task automatic idle;
    logic [31:0] v;
    v = 32'h1;
    for (int i = 0; i < 100 && v !== 32'h0; i++)
      rd(8'h2c, v);
    chk("engine idle", v, 32'h0);
  endtask
  task automatic wait_q(input int n);
    for (int i = 0; i < 400 && m.rd_log.size() < n; i++)
      @(posedge clk);
  endtask
  task automatic report_and_stop;
    $display("TB: checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Whole run is a few hundred cycles; the watchdog allows 50000
  initial
  begin
    #5000000;
    err_total++;
    $display("TB: watchdog expired");
    report_and_stop;
  end

  initial
  begin
    m.dmem[32'h400] = 32'h5a5a_0001;
    m.desc[32'h1000] = mk(16'h2, 4'h7);
    for (c = 1; c < 4; c++)
      m.desc[32'h1000 + 32'(c * 16)] = mk(16'h1, (c == 3) ? 4'h5 : 4'h1);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc("unmapped", 8'hfc, 32'h0);
    rc("pending", 8'h24, 32'h0);
    wr(8'h08, 32'h1000);
    wr(8'h0c, 32'h2000);
    wr(8'h00, 32'hf01);
    wr(8'h10, 32'h0);
    wr(8'h18, 32'h10);
    wr(8'h14, 32'h1);
    trig <= 4'h1;
    repeat (2) @(posedge clk);
    trig <= 4'h0;
    idle;
    chk("dst", m.dmem[32'h800], 32'h5a5a_0001);
    chk("wb entry", m.desc[32'h2000][31:0], 32'h6);
    rc("tc flag", 8'h20, 32'h1);
    rc("ch enable", 8'h14, 32'h0);
    rc("busy", 8'h28, 32'h0);
    chk("beat events", nbeat, 32'h2);
    chk("block events", nblk, 32'h1);
    $display("TB: single block test done");
    // Queue three channels with levels off, then release arbitration
    dly <= 4'h3;
    wr(8'h00, 32'h001);
    for (c = 1; c < 4; c++)
    begin
      wr(8'h10, 32'(c));
      wr(8'h18, (c == 3) ? 32'h1 : 32'h0);
      wr(8'h14, 32'h1);
    end
    wr(8'h30, 32'he);
    rc("pending", 8'h24, 32'he);
    rc("levels", 8'h2c, 32'h3);
    wr(8'h10, 32'h2);
    wr(8'h14, 32'h0);
    rc("pending", 8'h24, 32'ha);
    wr(8'h14, 32'h1);
    wr(8'h30, 32'h4);
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h3);
    rc("pending", 8'h24, 32'he);
    m.rd_log.delete();
    wr(8'h00, 32'hf01);
    wait_q(1);
    wr(8'h14, 32'h5);
    wait_q(3);
    idle;
    chk("grant 1", m.rd_log[0], 32'h1010);
    chk("grant 2", m.rd_log[1], 32'h1030);
    chk("grant 3", m.rd_log[2], 32'h1020);
    chk("block events", nblk, 32'h2);
    chk("event channel", {30'h0, kch}, 32'h3);
    $display("TB: arbitration test done");
    report_and_stop;
  end
endmodule
